// ---- hdl/mie_exec.sv ----
// Instruction execution unit of an 8-bit core: branch, skip, call, table
// read, watchdog clears, halt, add and logical AND.
// Assumes fetch/decode presents one decoded instruction with its operands,
// and that data memory read data for i_mem_addr is valid with i_issue.
// Function
// [RL1] Skips taken cost two cycles; fall-through costs one
// [RL2] Writes to the program counter low byte take two cycles
// [RL3] Pre-clear pair in either order clears timeout and sleep flags
// [RL4] Repeating the same pre-clear leaves watchdog and flags untouched
// [RL5] Watchdog clear resets counter and clears timeout and sleep flags
// [RL6] Add-with-carry sums work register, byte and carry; acc or memory
// [RL7] Add sums work register with byte or immediate; acc or memory
// [RL8] Every add updates overflow, zero, half carry and carry
// [RL9] AND with byte or immediate; acc or memory; only zero flag changes
// [RL10] Call pushes pc plus one, loads target, two cycles, no flags
// [RL11] Bit-test skips on selected bit clear or set; no flags changed
// [RL12] Byte-zero skip; load variant also copies byte to work register
// [RL13] Increment/decrement skip on zero; load variant writes acc only
// [RL14] Table read current or last page; high to lookup, low to memory
// [RL15] Clear zeroes the byte, bit form one bit; no flags changed
// [RL16] Nibble swap in memory, or into work register leaving memory
// [RL17] Return-load pops pc and loads immediate into work register
// [RL18] Halt stops, clears watchdog, sets sleep, clears timeout
// [RL19] Interrupt return pops pc and sets global irq enable
// [RL20] Carry from bit 7, half carry from bit 3, signed overflow
`timescale 1ns/100ps
`default_nettype none
module mie_exec (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Decoded instruction
  input wire logic i_issue,
  input wire mie_pkg::mie_op_t i_op,
  input wire logic [7:0] i_mem_addr,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_imm,
  input wire logic [2:0] i_bit,
  input wire logic [10:0] i_target,
  // Program memory word for table reads
  input wire logic [14:0] i_rom_word,
  // System events
  input wire logic i_wdt_timeout,
  input wire logic i_wake,
  input wire logic i_irq_ack,
  // Sequencing
  output logic o_ready,
  output logic [10:0] o_pc,
  output logic o_halt,
  // Work register and flags
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_half_carry_flag,
  output logic o_signed_range_exceeded,
  output logic o_zero,
  // Watchdog
  output logic o_timeout_flag,
  output logic o_sleep_flag,
  output logic o_watchdog_counter_clear,
  // Table read
  output logic [10:0] o_rom_addr,
  output logic o_rom_rd,
  output logic [7:0] o_lookup_high_byte,
  // Data memory write
  output logic o_mem_we,
  output logic [7:0] o_mem_waddr,
  output logic [7:0] o_mem_wdata,
  // Interrupt control
  output logic o_global_irq_enable
);
  typedef struct packed {
    mie_pkg::mie_phase_t phase;
    mie_pkg::mie_pre_t pre;
    logic ready;
    logic halt;
    logic [10:0] pc;
    logic [7:0] acc;
    logic carry;
    logic half;
    logic ovf;
    logic zero;
    logic timeout;
    logic sleep;
    logic wdt_clear;
    logic [3:0] sp;
    logic [10:0] rom_addr;
    logic rom_rd;
    logic [7:0] lookup_high;
    logic [7:0] tab_dest;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic irq_en;
  } mie_state_t;

  mie_state_t q_ff;
  mie_state_t nxt_q;
  logic [10:0] stack_ff [mie_pkg::STACK_DEPTH];
  logic push_en;
  logic [10:0] push_data;
  logic dest_mem;
  logic skip;
  logic two_cyc;
  logic branch;
  logic [7:0] wr_data;
  logic [10:0] pop_data;
  mie_alu_if alu_bus ();

  // ==========================================================================
  // Arithmetic unit
  mie_alu u_alu (
    .bus(alu_bus.alu)
  );

  // Top of stack; sp points at the next free entry and wraps past the last
  assign pop_data = stack_ff[q_ff.sp - mie_pkg::SP_STEP];

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_q = q_ff;
    push_en = 1'b0;
    push_data = q_ff.pc + mie_pkg::PC_STEP;
    dest_mem = 1'b0;
    skip = 1'b0;
    two_cyc = 1'b0;
    branch = 1'b0;
    wr_data = i_mem_rdata;
    alu_bus.op = mie_pkg::alu_pass;
    alu_bus.a = q_ff.acc;
    alu_bus.b = i_mem_rdata;
    alu_bus.cin = 1'b0;
    nxt_q.wdt_clear = 1'b0;
    nxt_q.mem_we = 1'b0;
    if (i_irq_ack) begin
      nxt_q.irq_en = 1'b0;
    end
    case (q_ff.phase)
      mie_pkg::ph_run: begin
        if (i_issue) begin
          nxt_q.pre = mie_pkg::pre_none;
          case (i_op)
            mie_pkg::op_add_acc_mem, mie_pkg::op_add_acc_imm,
            mie_pkg::op_add_into_memory, mie_pkg::op_add_carry_acc_mem,
            mie_pkg::op_add_with_carry_to_memory: begin
              alu_bus.op = mie_pkg::alu_add;
              if (i_op == mie_pkg::op_add_acc_imm) begin
                alu_bus.b = i_imm; // [RL7]
              end
              if (i_op == mie_pkg::op_add_carry_acc_mem ||
                  i_op == mie_pkg::op_add_with_carry_to_memory) begin
                alu_bus.cin = q_ff.carry; // [RL6]
              end
              dest_mem = (i_op == mie_pkg::op_add_into_memory) ||
                         (i_op == mie_pkg::op_add_with_carry_to_memory); // [RL6] [RL7]
              nxt_q.carry = alu_bus.cout; // [RL8]
              nxt_q.half = alu_bus.hcar; // [RL8]
              nxt_q.ovf = alu_bus.ovf; // [RL8]
              nxt_q.zero = alu_bus.zero; // [RL8]
            end
            mie_pkg::op_and_acc_mem, mie_pkg::op_and_acc_imm,
            mie_pkg::op_and_into_memory: begin
              alu_bus.op = mie_pkg::alu_and;
              if (i_op == mie_pkg::op_and_acc_imm) begin
                alu_bus.b = i_imm;
              end
              dest_mem = (i_op == mie_pkg::op_and_into_memory);
              nxt_q.zero = alu_bus.zero; // Only zero moves [RL9]
            end
            mie_pkg::op_jump: begin
              nxt_q.pc = i_target;
              branch = 1'b1;
              two_cyc = 1'b1;
            end
            mie_pkg::op_skip_if_null, mie_pkg::op_skip_if_null_load: begin
              skip = (i_mem_rdata == 8'h00); // [RL12]
              if (i_op == mie_pkg::op_skip_if_null_load) begin
                nxt_q.acc = i_mem_rdata; // [RL12]
              end
            end
            mie_pkg::op_skip_if_bit_clear: begin
              skip = !i_mem_rdata[i_bit]; // [RL11]
            end
            mie_pkg::op_skip_if_bit_set: begin
              skip = i_mem_rdata[i_bit]; // [RL11]
            end
            mie_pkg::op_increment_skip_if_null, mie_pkg::op_decrement_skip_if_null,
            mie_pkg::op_decrement_skip_load: begin
              alu_bus.op = (i_op == mie_pkg::op_increment_skip_if_null) ?
                           mie_pkg::alu_inc : mie_pkg::alu_dec;
              skip = alu_bus.zero; // [RL13]
              if (i_op == mie_pkg::op_decrement_skip_load) begin
                nxt_q.acc = alu_bus.res; // Memory left alone [RL13]
              end else begin
                dest_mem = 1'b1; // [RL13]
              end
            end
            mie_pkg::op_call: begin
              push_en = 1'b1; // Return address is pc plus one [RL10]
              nxt_q.sp = q_ff.sp + mie_pkg::SP_STEP;
              nxt_q.pc = i_target; // [RL10]
              branch = 1'b1;
              two_cyc = 1'b1; // [RL10]
            end
            mie_pkg::op_return, mie_pkg::op_return_load,
            mie_pkg::op_interrupt_return: begin
              nxt_q.sp = q_ff.sp - mie_pkg::SP_STEP;
              nxt_q.pc = pop_data; // [RL17] [RL19]
              branch = 1'b1;
              two_cyc = 1'b1;
              if (i_op == mie_pkg::op_return_load) begin
                nxt_q.acc = i_imm; // [RL17]
              end
              if (i_op == mie_pkg::op_interrupt_return) begin
                nxt_q.irq_en = 1'b1; // Beats a same-cycle ack [RL19]
              end
            end
            mie_pkg::op_table_read_current_page, mie_pkg::op_table_read_last_page: begin
              // Word comes back next cycle, then lands in memory [RL14]
              nxt_q.rom_addr = (i_op == mie_pkg::op_table_read_last_page) ?
                               {mie_pkg::LAST_PAGE, q_ff.acc} : {q_ff.pc[10:8], q_ff.acc};
              nxt_q.rom_rd = 1'b1;
              nxt_q.tab_dest = i_mem_addr;
              two_cyc = 1'b1; // [RL14]
            end
            mie_pkg::op_clear_byte: begin
              wr_data = mie_pkg::BYTE_CLEAR; // [RL15]
              dest_mem = 1'b1;
            end
            mie_pkg::op_clear_bit: begin
              wr_data = i_mem_rdata & ~(mie_pkg::BIT_ONE << i_bit); // [RL15]
              dest_mem = 1'b1;
            end
            mie_pkg::op_watchdog_clear: begin
              nxt_q.wdt_clear = 1'b1; // [RL5]
              nxt_q.timeout = 1'b0; // [RL5]
              nxt_q.sleep = 1'b0; // [RL5]
            end
            mie_pkg::op_watchdog_preclear_first, mie_pkg::op_watchdog_preclear_second: begin
              // Only the partner completes the pair; a repeat just re-arms [RL3] [RL4]
              if ((i_op == mie_pkg::op_watchdog_preclear_first &&
                   q_ff.pre == mie_pkg::pre_second) ||
                  (i_op == mie_pkg::op_watchdog_preclear_second &&
                   q_ff.pre == mie_pkg::pre_first)) begin
                nxt_q.wdt_clear = 1'b1; // [RL3]
                nxt_q.timeout = 1'b0; // [RL3]
                nxt_q.sleep = 1'b0; // [RL3]
              end else begin
                nxt_q.pre = (i_op == mie_pkg::op_watchdog_preclear_first) ?
                            mie_pkg::pre_first : mie_pkg::pre_second; // [RL4]
              end
            end
            mie_pkg::op_nibble_exchange: begin
              alu_bus.op = mie_pkg::alu_swap;
              dest_mem = 1'b1; // [RL16]
            end
            mie_pkg::op_nibble_exchange_to_work: begin
              alu_bus.op = mie_pkg::alu_swap;
              nxt_q.acc = alu_bus.res; // [RL16]
            end
            mie_pkg::op_halt: begin
              nxt_q.halt = 1'b1; // [RL18]
              nxt_q.wdt_clear = 1'b1; // Counter and prescaler [RL18]
              nxt_q.sleep = 1'b1; // [RL18]
              nxt_q.timeout = 1'b0; // [RL18]
              nxt_q.phase = mie_pkg::ph_halted;
              nxt_q.ready = 1'b0;
            end
            default: begin
            end
          endcase
          // Arithmetic results not bound for memory go to the work register
          if (alu_bus.op == mie_pkg::alu_add || alu_bus.op == mie_pkg::alu_and) begin
            if (!dest_mem) begin
              nxt_q.acc = alu_bus.res; // [RL6] [RL7] [RL9]
            end
          end
          if (alu_bus.op != mie_pkg::alu_pass) begin
            wr_data = alu_bus.res;
          end
          if (!branch) begin
            nxt_q.pc = skip ? q_ff.pc + mie_pkg::PC_SKIP_STEP : q_ff.pc + mie_pkg::PC_STEP;
          end
          two_cyc = two_cyc || skip; // [RL1]
          if (dest_mem) begin
            if (i_mem_addr == mie_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE) begin
              // Prefetched word is stale, so a dummy cycle follows [RL2]
              nxt_q.pc = {q_ff.pc[10:8], wr_data};
              two_cyc = 1'b1; // [RL2]
            end else begin
              nxt_q.mem_we = 1'b1;
              nxt_q.mem_waddr = i_mem_addr;
              nxt_q.mem_wdata = wr_data;
            end
          end
          if (two_cyc) begin
            nxt_q.phase = mie_pkg::ph_second;
            nxt_q.ready = 1'b0;
          end
        end
      end
      mie_pkg::ph_second: begin
        if (q_ff.rom_rd) begin
          nxt_q.rom_rd = 1'b0;
          nxt_q.lookup_high = {1'b0, i_rom_word[14:8]}; // [RL14]
          nxt_q.mem_we = 1'b1; // [RL14]
          nxt_q.mem_waddr = q_ff.tab_dest;
          nxt_q.mem_wdata = i_rom_word[7:0];
        end
        nxt_q.phase = mie_pkg::ph_run;
        nxt_q.ready = 1'b1;
      end
      default: begin
        // Halted: state is held until a wake event
        if (i_wake) begin
          nxt_q.halt = 1'b0;
          nxt_q.phase = mie_pkg::ph_run;
          nxt_q.ready = 1'b1;
        end
      end
    endcase
    // A timeout in the same cycle as a clear must not be lost
    if (i_wdt_timeout) begin
      nxt_q.timeout = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_ff <= '{phase: mie_pkg::ph_run, pre: mie_pkg::pre_none, ready: 1'b1,
                pc: mie_pkg::PC_RST, acc: mie_pkg::ACC_RST, sp: mie_pkg::SP_RST,
                irq_en: mie_pkg::GLOBAL_IRQ_ENABLE_RST, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Return stack; no reset needed, entries are only read after a push
  always_ff @(posedge i_core_clk) begin
    if (push_en) begin
      stack_ff[q_ff.sp] <= push_data; // [RL10]
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign o_ready = q_ff.ready;
  assign o_pc = q_ff.pc;
  assign o_halt = q_ff.halt;
  assign o_acc = q_ff.acc;
  assign o_carry = q_ff.carry;
  assign o_half_carry_flag = q_ff.half;
  assign o_signed_range_exceeded = q_ff.ovf;
  assign o_zero = q_ff.zero;
  assign o_timeout_flag = q_ff.timeout;
  assign o_sleep_flag = q_ff.sleep;
  assign o_watchdog_counter_clear = q_ff.wdt_clear;
  assign o_rom_addr = q_ff.rom_addr;
  assign o_rom_rd = q_ff.rom_rd;
  assign o_lookup_high_byte = q_ff.lookup_high;
  assign o_mem_we = q_ff.mem_we;
  assign o_mem_waddr = q_ff.mem_waddr;
  assign o_mem_wdata = q_ff.mem_wdata;
  assign o_global_irq_enable = q_ff.irq_en;

  // ==========================================================================
  // Checks
  skip_two_cycle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL1]
    (i_issue && o_ready && i_op == mie_pkg::op_skip_if_null && i_mem_rdata == 8'h00)
    |=> !o_ready ##1 o_ready)
    else $error("taken skip did not take two cycles");
  fall_through_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL1]
    (i_issue && o_ready && i_op == mie_pkg::op_skip_if_bit_set && !i_mem_rdata[i_bit])
    |=> o_ready && o_pc == $past(o_pc) + mie_pkg::PC_STEP)
    else $error("untaken skip did not fall through in one cycle");
  pcl_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL2]
    (i_issue && o_ready && i_op == mie_pkg::op_clear_byte &&
     i_mem_addr == mie_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE)
    |=> !o_ready && !o_mem_we && o_pc[7:0] == 8'h00)
    else $error("pc low byte write not two cycles");
  preclear_pair_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL3]
    (i_issue && o_ready && i_op == mie_pkg::op_watchdog_preclear_second &&
     q_ff.pre == mie_pkg::pre_first && !i_wdt_timeout)
    |=> !o_timeout_flag && !o_sleep_flag && o_watchdog_counter_clear)
    else $error("pre-clear pair did not clear flags");
  preclear_repeat_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL4]
    (i_issue && o_ready && i_op == mie_pkg::op_watchdog_preclear_first &&
     q_ff.pre != mie_pkg::pre_second)
    |=> !o_watchdog_counter_clear && o_sleep_flag == $past(o_sleep_flag))
    else $error("lone pre-clear had an effect");
  wdt_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL5]
    (i_issue && o_ready && i_op == mie_pkg::op_watchdog_clear && !i_wdt_timeout)
    |=> o_watchdog_counter_clear && !o_timeout_flag && !o_sleep_flag)
    else $error("watchdog clear incomplete");
  add_carry_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL6]
    (i_issue && o_ready && i_op == mie_pkg::op_add_carry_acc_mem)
    |=> o_acc == 8'($past(o_acc) + $past(i_mem_rdata) + {7'h00, $past(o_carry)}))
    else $error("add with carry sum wrong");
  add_flags_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL8]
    (i_issue && o_ready && i_op == mie_pkg::op_add_acc_imm)
    |=> o_carry == ({1'b0, $past(o_acc)} + {1'b0, $past(i_imm)} > 9'h0FF) &&
        o_zero == (o_acc == 8'h00))
    else $error("add flags wrong");
  and_flags_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL9]
    (i_issue && o_ready && i_op == mie_pkg::op_and_acc_imm)
    |=> $stable(o_carry) && $stable(o_half_carry_flag) && o_acc == ($past(o_acc) & $past(i_imm)))
    else $error("and result or flags wrong");
  call_target_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL10]
    (i_issue && o_ready && i_op == mie_pkg::op_call)
    |=> o_pc == $past(i_target) && !o_ready ##1 o_ready)
    else $error("call did not load target in two cycles");
  table_read_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL14]
    (i_issue && o_ready && i_op == mie_pkg::op_table_read_last_page)
    |=> o_rom_rd && o_rom_addr[10:8] == mie_pkg::LAST_PAGE ##1 o_mem_we && o_ready)
    else $error("table read sequence wrong");
  halt_flags_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL18]
    (i_issue && o_ready && i_op == mie_pkg::op_halt && !i_wdt_timeout)
    |=> o_halt && o_sleep_flag && !o_timeout_flag && o_watchdog_counter_clear && !o_ready)
    else $error("halt effects wrong");
  irq_return_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RL19]
    (i_issue && o_ready && i_op == mie_pkg::op_interrupt_return)
    |=> o_global_irq_enable)
    else $error("interrupt return left irq disabled");
endmodule
`default_nettype wire

// ---- pkg/mie_pkg.sv ----
// Shared types and constants of the instruction execution unit.
// Assumes a core that hands over one decoded instruction at a time.
package mie_pkg;
  // ==========================================================================
  // Widths and fixed values
  localparam int unsigned STACK_DEPTH = 16;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [10:0] PC_STEP = 11'h001;
  localparam logic [10:0] PC_SKIP_STEP = 11'h002;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam logic [3:0] SP_RST = 4'h0;
  localparam logic [3:0] SP_STEP = 4'h1;
  // Data memory address of the program counter low byte
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW_BYTE = 8'h06;
  // Upper program address bits of the last page
  localparam logic [2:0] LAST_PAGE = 3'h7;
  // Reset value of the irq control register enable bit
  localparam logic GLOBAL_IRQ_ENABLE_RST = 1'b0;

  // ==========================================================================
  // Decoded instructions handed to the unit
  typedef enum logic [4:0] {
    op_nop,
    op_add_acc_mem,
    op_add_acc_imm,
    op_add_into_memory,
    op_add_carry_acc_mem,
    op_add_with_carry_to_memory,
    op_and_acc_mem,
    op_and_acc_imm,
    op_and_into_memory,
    op_jump,
    op_skip_if_null,
    op_skip_if_null_load,
    op_skip_if_bit_clear,
    op_skip_if_bit_set,
    op_increment_skip_if_null,
    op_decrement_skip_if_null,
    op_decrement_skip_load,
    op_call,
    op_return,
    op_return_load,
    op_interrupt_return,
    op_table_read_current_page,
    op_table_read_last_page,
    op_clear_byte,
    op_clear_bit,
    op_watchdog_clear,
    op_watchdog_preclear_first,
    op_watchdog_preclear_second,
    op_nibble_exchange,
    op_nibble_exchange_to_work,
    op_halt
  } mie_op_t;

  // Arithmetic unit functions
  typedef enum logic [2:0] {
    alu_pass,
    alu_add,
    alu_and,
    alu_inc,
    alu_dec,
    alu_swap
  } mie_alu_op_t;

  // Execution phases
  typedef enum logic [1:0] {
    ph_run,
    ph_second,
    ph_halted
  } mie_phase_t;

  // Unpaired watchdog pre-clear of the previous instruction
  typedef enum logic [1:0] {
    pre_none,
    pre_first,
    pre_second
  } mie_pre_t;
endpackage

// ---- pkg/mie_alu_if.sv ----
// Carrier between the execution unit and its arithmetic unit.
// Assumes both ends sit on the same clock; the path is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface mie_alu_if;
  mie_pkg::mie_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic hcar;
  logic ovf;
  logic zero;
  modport alu (input op, a, b, cin, output res, cout, hcar, ovf, zero);
  modport user (output op, a, b, cin, input res, cout, hcar, ovf, zero);
endinterface
`default_nettype wire

// ---- hdl/mie_alu.sv ----
// Combinational byte arithmetic: add, and, increment, decrement, swap.
// Assumes the user registers every result it keeps.
`timescale 1ns/100ps
`default_nettype none
module mie_alu (
  // Operands and results
  mie_alu_if.alu bus
);
  logic [8:0] sum9;
  logic [4:0] low5;

  // ==========================================================================
  // Function select; carry, half carry and overflow come from the add path, zero from the result
  always_comb begin
    sum9 = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
    low5 = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
    bus.cout = sum9[8]; // Carry out of bit 7 [RL20]
    bus.hcar = low5[4]; // Carry out of bit 3 [RL20]
    // Same-sign operands giving a different-sign sum [RL20]
    bus.ovf = (bus.a[7] == bus.b[7]) && (sum9[7] != bus.a[7]);
    case (bus.op)
      mie_pkg::alu_add: bus.res = sum9[7:0];
      mie_pkg::alu_and: bus.res = bus.a & bus.b;
      mie_pkg::alu_inc: bus.res = bus.b + 8'h01;
      mie_pkg::alu_dec: bus.res = bus.b - 8'h01;
      mie_pkg::alu_swap: bus.res = {bus.b[3:0], bus.b[7:4]}; // [RL16]
      default: bus.res = bus.b;
    endcase
    bus.zero = (bus.res == 8'h00);
  end
endmodule
`default_nettype wire

// ---- testbench/mie_exec_tb.sv ----
// Self-checking bench of the instruction execution unit.
// Assumes the unit alone; this bench drives every input on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module mie_exec_tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, iv = 1'b0, tmo = 1'b0, wake = 1'b0;
  mie_pkg::mie_op_t op = mie_pkg::op_nop;
  logic [7:0] rd = 8'h00, imm = 8'h00, ma = 8'h20, acc, wd, wa, lh;
  logic [14:0] rw = 15'h0000;
  logic [2:0] bsel = 3'h0;
  logic [10:0] tgt = 11'h000, pc, pc0, ret, ra;
  logic rdy, hlt, cy, hc, ov, z, to, sl, wclr, we, rr, ie;
  int fail_count = 0, n_compared = 0;
  // ==========================================================================
  // Unit under test; irq acknowledge is left idle
  mie_exec u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_issue(iv), .i_op(op),
    .i_mem_addr(ma), .i_mem_rdata(rd), .i_imm(imm), .i_bit(bsel), .i_target(tgt),
    .i_rom_word(rw), .i_wdt_timeout(tmo), .i_wake(wake), .i_irq_ack(1'b0),
    .o_ready(rdy), .o_pc(pc), .o_halt(hlt), .o_acc(acc), .o_carry(cy),
    .o_half_carry_flag(hc), .o_signed_range_exceeded(ov), .o_zero(z),
    .o_timeout_flag(to), .o_sleep_flag(sl), .o_watchdog_counter_clear(wclr),
    .o_rom_addr(ra), .o_rom_rd(rr), .o_lookup_high_byte(lh), .o_mem_we(we),
    .o_mem_waddr(wa), .o_mem_wdata(wd), .o_global_irq_enable(ie));
  // ==========================================================================
  // Shared compare, issue and event tasks
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Flags packed as overflow, zero, half carry, carry
  task automatic flg(input logic [3:0] e);
    chk("flags", {7'h00, e}, {7'h00, ov, z, hc, cy});
  endtask
  // Results are looked at just after the taking edge, once they have landed
  task automatic go(input mie_pkg::mie_op_t o, input logic [7:0] m, input logic [7:0] x);
    pc0 = pc;
    @(posedge clk);
    iv <= 1'b1; op <= o; rd <= m; imm <= x;
    @(posedge clk);
    iv <= 1'b0;
    #1;
  endtask
  task automatic pulse_tmo();
    @(posedge clk) tmo <= 1'b1;
    @(posedge clk) tmo <= 1'b0;
    #1 chk("timeout", 11'h001, {10'h000, to});
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_add();
    go(mie_pkg::op_add_acc_imm, 8'h00, 8'h7F); chk("acc", 11'h07F, {3'h0, acc});
    go(mie_pkg::op_add_acc_imm, 8'h00, 8'h01); flg(4'hA);
    go(mie_pkg::op_add_into_memory, 8'h80, 8'h00); flg(4'hD);
    chk("wdata", {2'h0, 1'b1, 8'h00}, {2'h0, we, wd});
    chk("acc", 11'h080, {3'h0, acc});
    go(mie_pkg::op_add_carry_acc_mem, 8'h0F, 8'h00); flg(4'h2);
    chk("acc", 11'h090, {3'h0, acc});
    go(mie_pkg::op_and_acc_imm, 8'h00, 8'h0F); flg(4'h6);
  endtask
  task automatic t_skip();
    go(mie_pkg::op_skip_if_null, 8'h00, 8'h00); chk("pc", pc0 + 11'h002, pc);
    chk("ready", 11'h000, {10'h000, rdy});
    go(mie_pkg::op_skip_if_null, 8'h05, 8'h00); chk("pc", pc0 + 11'h001, pc);
    @(posedge clk) bsel <= 3'h3;
    go(mie_pkg::op_skip_if_bit_set, 8'h08, 8'h00); chk("pc", pc0 + 11'h002, pc);
    go(mie_pkg::op_skip_if_bit_set, 8'hF7, 8'h00); chk("pc", pc0 + 11'h001, pc);
  endtask
  task automatic t_call();
    @(posedge clk) tgt <= 11'h123;
    go(mie_pkg::op_call, 8'h00, 8'h00); chk("pc", 11'h123, pc);
    ret = pc0 + 11'h001;
    go(mie_pkg::op_return_load, 8'h00, 8'h5A); chk("pc", ret, pc);
    chk("acc", 11'h05A, {3'h0, acc});
    flg(4'h6);
  endtask
  // Halt, then full clear, then a broken and a completed pre-clear pair
  task automatic t_wdt();
    go(mie_pkg::op_halt, 8'h00, 8'h00); chk("halt", 11'h006, {8'h00, hlt, sl, to});
    chk("wdt_clear", 11'h001, {10'h000, wclr});
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    #1 chk("resume", 11'h001, {9'h000, hlt, rdy});
    pulse_tmo();
    go(mie_pkg::op_watchdog_clear, 8'h00, 8'h00); chk("wdt", 11'h001, {8'h00, sl, to, wclr});
    pulse_tmo();
    go(mie_pkg::op_watchdog_preclear_first, 8'h00, 8'h00);
    go(mie_pkg::op_watchdog_preclear_first, 8'h00, 8'h00); chk("wdt", 11'h002, {9'h000, to, wclr});
    go(mie_pkg::op_watchdog_preclear_second, 8'h00, 8'h00); chk("wdt", 11'h001, {9'h000, to, wclr});
  endtask
  // Table read, pc low byte write, interrupt return and memory-free forms
  task automatic t_misc();
    @(posedge clk) rw <= 15'h5A3C;
    go(mie_pkg::op_table_read_last_page, 8'h00, 8'h00);
    chk("rom_addr", 11'h75A, ra);
    chk("rom_rd", 11'h001, {10'h000, rr});
    @(posedge clk) #1 chk("table", 11'h13C, {2'h0, we, wd});
    chk("lookup", 11'h05A, {3'h0, lh});
    chk("waddr", 11'h020, {3'h0, wa});
    go(mie_pkg::op_nibble_exchange_to_work, 8'h3C, 8'h00);
    chk("swap", 11'h0C3, {2'h0, we, acc});
    go(mie_pkg::op_decrement_skip_load, 8'h01, 8'h00);
    chk("dec", 11'h000, {2'h0, we, acc});
    chk("pc", pc0 + 11'h002, pc);
    go(mie_pkg::op_clear_bit, 8'hFF, 8'h00);
    chk("clr_bit", 11'h1F7, {2'h0, we, wd});
    flg(4'h6);
    @(posedge clk) ma <= 8'h06;
    go(mie_pkg::op_clear_byte, 8'h5A, 8'h00);
    chk("pcl", {pc0[10:8], 8'h00}, pc);
    chk("pcl_cyc", 11'h000, {9'h000, we, rdy});
    go(mie_pkg::op_call, 8'h00, 8'h00);
    ret = pc0 + 11'h001;
    go(mie_pkg::op_interrupt_return, 8'h00, 8'h00);
    chk("interrupt_return", ret, pc);
    chk("irq_en", 11'h001, {10'h000, ie});
  endtask
  task automatic end_of_test();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, main sequence and hang guard (tests need well under 100 cycles)
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_add();
    t_skip();
    t_call();
    t_wdt();
    t_misc();
    end_of_test();
  end
  initial begin
    repeat (500) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
